// *** common/exc_pkg.sv ***
// Constants and types shared by the exception sequencer files
package exc_pkg;
    localparam logic [5:0] VEC_RESET = 6'h00;
    localparam logic [5:0] VEC_NMI = 6'h07;
    localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
    localparam logic [5:0] VEC_EXT_BASE = 6'h0c;
    localparam logic [5:0] VEC_INT_FIRST = 6'h14;
    localparam logic [5:0] VEC_INT_LAST = 6'h3c;
    localparam logic [5:0] VEC_RSV_LO_LAST = 6'h06;
    localparam logic [5:0] VEC_RSV_HI_FIRST = 6'h12;
    localparam logic [5:0] VEC_RSV_HI_LAST = 6'h13;
    localparam int EXT_LINES = 6;
    localparam int MASK_BIT_POS = 7;
    localparam int USER_BIT_POS = 6;
    localparam logic [23:0] STACK_STEP = 24'h000002;
    localparam logic [15:0] VEC_SCALE_SHIFT = 16'h0002;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_MIN_CYCLES = 10;
    localparam int POWERUP_HOLD_MS = 20;
    localparam int POWERUP_HOLD_CYCLES = POWERUP_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_RESET,
        SRC_IRQ,
        SRC_TRAP
    } src_type;
endpackage

// *** hdl/exc_arbiter.sv ***
// Fixed-priority selection of the next exception and its vector number
`timescale 1ns/1ns
module exc_arbiter (
    input wire logic reset_pend_in, // Reset exception waiting
    input wire logic irq_pend_in, // Interrupt request allowed
    input wire logic [5:0] irq_vec_in, // Interrupt vector number
    input wire logic trap_pend_in, // Trap instruction executed
    input wire logic [1:0] trap_num_in, // Trap vector select
    output exc_pkg::src_type src_out, // Chosen source
    output logic [5:0] vec_out // Chosen vector number
);
    always_comb begin
        src_out = exc_pkg::SRC_NONE;
        vec_out = exc_pkg::VEC_RESET;
        if (reset_pend_in) begin
            src_out = exc_pkg::SRC_RESET;
        end else if (irq_pend_in) begin
            src_out = exc_pkg::SRC_IRQ;
            vec_out = irq_vec_in;
        end else if (trap_pend_in) begin
            src_out = exc_pkg::SRC_TRAP;
            vec_out = exc_pkg::VEC_TRAP_BASE + {4'h0, trap_num_in};
        end
    end
endmodule

// *** hdl/exception_reset_sequencer.sv ***
// Exception and reset sequencer that drives the CPU core through context save and vector fetch
`timescale 1ns/1ns
// Behaviour
// - Reset beats interrupt, interrupt beats trap when pending together.
// - Trap instruction is accepted in program execution after the first instruction unless an interrupt wins that cycle, never masked.
// - Interrupts wait for the current instruction or exception sequence to finish.
// - Reset sequence starts once the synchronised reset input reads high.
// - Trap and interrupt push program counter and flags onto stack.
// - After the push, main interrupt mask bit is set.
// - Vector address formed, start address read, execution jumps there.
// - Reset skips the push; it only masks and fetches the vector.
// - Vector map: 7 NMI, 8-11 traps, 12-17 external, 20-60 internal.
// - Vectors 1-6 and 18-19 are never used.
// - While reset input is low everything halts in reset state.
// - Reset initialises CPU state and peripherals, sets main mask bit.
// - Reset reads the longword at address zero and starts there.
// - A watchdog overflow also resets the device.
// - After reset all interrupts, NMI included, blocked until first instruction.
// - First instruction always runs right after reset, before other exceptions.
// - Trap sets mask and user mask if user select is zero, else mask only.
// - Trap picks one of four vectors from instruction code.
module exception_reset_sequencer (
    input wire logic sys_clk_in, // System clock
    input wire logic rst_n_in, // Synchronous power-on reset of this logic
    input wire logic reset_input_n_in, // External reset pin, active low
    input wire logic wdt_overflow_in, // Watchdog overflow pulse
    input wire logic insn_done_in, // Core finished an instruction
    input wire logic trap_instruction_op_in, // Trap instruction executing
    input wire logic [1:0] trap_num_in, // Trap vector select from opcode
    input wire logic irq_req_in, // Interrupt controller request
    input wire logic [5:0] irq_vec_in, // Interrupt vector number
    input wire logic user_bit_select_in, // One: user mask bit is a plain user bit
    input wire logic [15:0] pc_in, // Program counter from core
    input wire logic [7:0] flags_in, // Condition flag register from core
    input wire logic [23:0] sp_in, // Stack pointer from core
    input wire logic bus_ack_in, // Memory access complete
    input wire logic [15:0] bus_rdata_in, // Memory read data
    output logic bus_req_out, // Memory access request
    output logic bus_we_out, // Memory write
    output logic [23:0] bus_addr_out, // Memory address
    output logic [15:0] bus_wdata_out, // Memory write data
    output logic core_halt_out, // Core held, not executing
    output logic core_init_out, // Reset internal and peripheral state
    output logic core_load_out, // Pulse: load pc, flags, sp below
    output logic [31:0] core_pc_out, // New program counter
    output logic [7:0] condition_flag_reg_out, // New flag register
    output logic [23:0] core_sp_out, // New stack pointer
    output logic irq_ack_out // Pulse: interrupt accepted
);
    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_PUSH_PC,
        ST_PUSH_FLAGS,
        ST_VEC_HI,
        ST_VEC_LO,
        ST_FIRST
    } state_type;

    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        state_type state;
        exc_pkg::src_type src;
        logic [5:0] vec;
        logic [23:0] sp;
        logic [7:0] flags;
        logic [15:0] pc;
        logic [15:0] vec_hi;
        logic load;
        logic ack;
    } regs_type;

    regs_type r_q;
    regs_type r_d;
    exc_pkg::src_type arb_src;
    logic [5:0] arb_vec;
    logic reset_hold;
    logic irq_allowed;

    function automatic logic [23:0] vec_addr(input logic [5:0] v);
        vec_addr = {8'h00, 16'(v) << exc_pkg::VEC_SCALE_SHIFT};
    endfunction

    function automatic logic vec_legal(input logic [5:0] v);
        vec_legal = (v == exc_pkg::VEC_NMI) ||
                    (v >= exc_pkg::VEC_EXT_BASE && v < exc_pkg::VEC_RSV_HI_FIRST) ||
                    (v >= exc_pkg::VEC_INT_FIRST && v <= exc_pkg::VEC_INT_LAST);
    endfunction

    // Pin and watchdog both hold the reset state
    assign reset_hold = !r_q.pin_sync || wdt_overflow_in;
    // Only between instructions, and only for legal vectors
    assign irq_allowed = irq_req_in && insn_done_in && vec_legal(irq_vec_in);

    exc_arbiter u_arb (
        .reset_pend_in(reset_hold),
        .irq_pend_in(irq_allowed),
        .irq_vec_in(irq_vec_in),
        .trap_pend_in(trap_instruction_op_in),
        .trap_num_in(trap_num_in),
        .src_out(arb_src),
        .vec_out(arb_vec)
    );

    always_comb begin
        r_d = r_q;
        r_d.pin_meta = reset_input_n_in;
        r_d.pin_sync = r_q.pin_meta;
        r_d.pin_prev = r_q.pin_sync;
        r_d.load = 1'b0;
        r_d.ack = 1'b0;
        if (reset_hold) begin
            r_d.state = ST_RESET;
        end else begin
            unique case (r_q.state)
                ST_RESET: begin
                    // Vector fetch begins the cycle after the synchronised pin first reads high
                    r_d.src = exc_pkg::SRC_RESET;
                    r_d.vec = exc_pkg::VEC_RESET;
                    r_d.flags = 8'h00;
                    r_d.flags[exc_pkg::MASK_BIT_POS] = 1'b1;
                    r_d.state = ST_VEC_HI;
                end
                ST_RUN: begin
                    if (arb_src != exc_pkg::SRC_NONE) begin
                        r_d.src = arb_src;
                        r_d.vec = arb_vec;
                        r_d.pc = pc_in;
                        r_d.flags = flags_in;
                        r_d.sp = sp_in;
                        r_d.ack = (arb_src == exc_pkg::SRC_IRQ);
                        r_d.state = ST_PUSH_PC;
                    end
                end
                ST_PUSH_PC: begin
                    if (bus_ack_in) begin
                        r_d.sp = r_q.sp - exc_pkg::STACK_STEP;
                        r_d.state = ST_PUSH_FLAGS;
                    end
                end
                ST_PUSH_FLAGS: begin
                    if (bus_ack_in) begin
                        r_d.sp = r_q.sp - exc_pkg::STACK_STEP;
                        r_d.flags[exc_pkg::MASK_BIT_POS] = 1'b1;
                        if (r_q.src == exc_pkg::SRC_TRAP && !user_bit_select_in) begin
                            r_d.flags[exc_pkg::USER_BIT_POS] = 1'b1;
                        end
                        r_d.state = ST_VEC_HI;
                    end
                end
                ST_VEC_HI: begin
                    if (bus_ack_in) begin
                        r_d.vec_hi = bus_rdata_in;
                        r_d.state = ST_VEC_LO;
                    end
                end
                ST_VEC_LO: begin
                    if (bus_ack_in) begin
                        r_d.load = 1'b1;
                        r_d.pc = bus_rdata_in;
                        // After reset one instruction runs with every exception but reset blocked
                        r_d.state = (r_q.src == exc_pkg::SRC_RESET) ? ST_FIRST : ST_RUN;
                    end
                end
                ST_FIRST: begin
                    if (insn_done_in) begin
                        r_d.state = ST_RUN;
                    end
                end
                default: r_d.state = ST_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    always_comb begin
        bus_req_out = 1'b0;
        bus_we_out = 1'b0;
        bus_addr_out = 24'h000000;
        bus_wdata_out = 16'h0000;
        unique case (r_q.state)
            ST_PUSH_PC: begin
                bus_req_out = 1'b1;
                bus_we_out = 1'b1;
                bus_addr_out = r_q.sp - exc_pkg::STACK_STEP;
                bus_wdata_out = r_q.pc;
            end
            ST_PUSH_FLAGS: begin
                bus_req_out = 1'b1;
                bus_we_out = 1'b1;
                bus_addr_out = r_q.sp - exc_pkg::STACK_STEP;
                bus_wdata_out = {r_q.flags, 8'h00};
            end
            ST_VEC_HI: begin
                bus_req_out = 1'b1;
                bus_addr_out = vec_addr(r_q.vec);
            end
            ST_VEC_LO: begin
                bus_req_out = 1'b1;
                bus_addr_out = vec_addr(r_q.vec) + 24'h000002;
            end
            default: ;
        endcase
    end

    assign core_halt_out = (r_q.state != ST_RUN) && (r_q.state != ST_FIRST);
    assign core_init_out = (r_q.state == ST_RESET);
    assign core_load_out = r_q.load;
    assign core_pc_out = {r_q.vec_hi, r_q.pc};
    assign condition_flag_reg_out = r_q.flags;
    assign core_sp_out = r_q.sp;
    assign irq_ack_out = r_q.ack;

    reset_halt_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wdt_overflow_in |=> core_halt_out) else $error("core not halted by watchdog");
    reset_noirq_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (r_q.state == ST_FIRST && !reset_hold) |=>
        ((r_q.state == ST_FIRST || r_q.state == ST_RUN) && !irq_ack_out))
        else $error("exception taken during first insn");
    reset_exit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (r_q.state == ST_RESET && r_q.pin_sync && !r_q.pin_prev && !wdt_overflow_in) |=>
        r_q.state == ST_VEC_HI) else $error("reset exit not immediate");
    reset_nopush_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (r_q.src == exc_pkg::SRC_RESET) |-> !bus_we_out) else $error("reset pushed stack");
    reset_vector_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ($past(r_q.state) == ST_RESET && r_q.state == ST_VEC_HI) |->
        bus_addr_out == 24'h000000) else $error("bad reset vector");
    mask_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        core_load_out |-> condition_flag_reg_out[exc_pkg::MASK_BIT_POS])
        else $error("mask bit clear at jump");
    trap_accept_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (r_q.state == ST_RUN && !reset_hold && trap_instruction_op_in) |=>
        r_q.state == ST_PUSH_PC) else $error("trap not accepted");
    irq_boundary_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        irq_ack_out |-> $past(insn_done_in)) else $error("irq mid instruction");
    push_order_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (r_q.state == ST_PUSH_PC && bus_ack_in && !reset_hold) |=>
        r_q.sp == $past(r_q.sp) - exc_pkg::STACK_STEP) else $error("sp not stepped");
    vec_legal_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        irq_ack_out |-> vec_legal(r_q.vec)) else $error("reserved vector used");
endmodule

// *** tb/mem_model.sv ***
// Memory partner model answering the sequencer's bus with wait states
`timescale 1ns/1ns
module mem_model (
    input wire logic clk_in, // System clock
    input wire logic req_in, // Access request
    input wire logic we_in, // Write
    input wire logic [23:0] addr_in, // Address
    input wire logic [15:0] wdata_in, // Write data
    input wire logic [1:0] lat_in, // Wait cycles before acknowledge
    output logic ack_out, // Access done
    output logic [15:0] rdata_out // Read data
);
    logic [23:0] wa [0:1];
    logic [15:0] wd [0:1];
    int writes = 0;
    int cnt = 0;
    initial begin
        ack_out = 1'b0;
        rdata_out = 16'h0000;
    end
    // Read data is a fixed function of the address so vector contents are predictable
    always @(posedge clk_in) begin
        #1;
        if (ack_out) begin
            ack_out <= 1'b0;
            cnt <= 0;
            rdata_out <= ~rdata_out; // Idle bus never shows a stale value
        end else if (req_in && cnt >= lat_in) begin
            ack_out <= 1'b1;
            if (we_in) begin
                rdata_out <= ~rdata_out;
                wa[writes & 1] <= addr_in;
                wd[writes & 1] <= wdata_in;
                writes <= writes + 1;
            end else begin
                rdata_out <= addr_in[15:0] + 16'h1000;
            end
        end else begin
            rdata_out <= ~rdata_out;
            if (req_in) cnt <= cnt + 1;
        end
    end
endmodule

// *** tb/tb_exception_reset_sequencer.sv ***
// Self-checking bench for the exception and reset sequencer
`timescale 1ns/1ns
module tb_exception_reset_sequencer;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic pin_n = 1'b0; // power-up hold, shortened to the bench reset span
    logic wdt = 1'b0, done = 1'b0, trap = 1'b0, irq = 1'b0, sel = 1'b1;
    logic [1:0] tnum = 2'h0, lat = 2'h0;
    logic [5:0] ivec = 6'h00;
    logic [15:0] pc = 16'h0000, rdata, wdata;
    logic [7:0] fl = 8'h00, fl_o;
    logic [23:0] sp = 24'h000000, addr, sp_o;
    logic [31:0] pc_o;
    logic ack, req, we, halt, init, load, iack;
    int errors = 0, tests_run = 0;
    exception_reset_sequencer u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .reset_input_n_in(pin_n), .wdt_overflow_in(wdt), .insn_done_in(done),
        .trap_instruction_op_in(trap), .trap_num_in(tnum), .irq_req_in(irq), .irq_vec_in(ivec),
        .user_bit_select_in(sel), .pc_in(pc), .flags_in(fl), .sp_in(sp), .bus_ack_in(ack),
        .bus_rdata_in(rdata), .bus_req_out(req), .bus_we_out(we), .bus_addr_out(addr),
        .bus_wdata_out(wdata), .core_halt_out(halt), .core_init_out(init),
        .core_load_out(load), .core_pc_out(pc_o), .condition_flag_reg_out(fl_o),
        .core_sp_out(sp_o), .irq_ack_out(iack));
    mem_model u_mem (.clk_in(sys_clk_in), .req_in(req), .we_in(we), .addr_in(addr),
        .wdata_in(wdata), .lat_in(lat), .ack_out(ack), .rdata_out(rdata));
    initial begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic conclude;
        $display("Counts: tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic pulse;
        done = 1'b1;
        tick(1);
        done = 1'b0;
    endtask
    // Bounded wait for the load pulse, then the new core state
    task automatic wait_load(input logic [5:0] v, input logic [7:0] m, input logic [7:0] e,
                             input logic [23:0] s);
        int n = 0;
        logic [15:0] va;
        va = {8'h00, v, 2'b00};
        while (load !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check({31'h0, load}, 32'h1);
        check(pc_o, {va + 16'h1000, va + 16'h1002});
        check({24'h0, fl_o & m}, {24'h0, e});
        if (s !== 24'hffffff) check({8'h0, sp_o}, {8'h0, s});
        tick(1);
    endtask
    task automatic wait_ack;
        int n = 0;
        while (iack !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check({31'h0, iack}, 32'h1);
        irq = 1'b0;
    endtask
    task automatic check_push(input int w0);
        check(u_mem.writes - w0, 2);
        check({8'h0, u_mem.wa[0]}, {8'h0, sp - 24'h2});
        check({8'h0, u_mem.wa[1]}, {8'h0, sp - 24'h4});
        check({16'h0, u_mem.wd[0]}, {16'h0, pc});
        check({24'h0, u_mem.wd[1][15:8]}, {24'h0, fl});
    endtask
    task automatic test_reset(input logic use_wdt);
        int w0 = u_mem.writes;
        if (use_wdt) wdt = 1'b1;
        else pin_n = 1'b0;
        tick(exc_pkg::RESET_MIN_CYCLES);
        check({30'h0, halt, init}, 32'h3);
        wdt = 1'b0;
        pin_n = 1'b1;
        wait_load(6'h00, 8'h80, 8'h80, 24'hffffff);
        check(u_mem.writes - w0, 0);
        irq = 1'b1;
        ivec = 6'h07;
        tick(5);
        check({30'h0, halt, iack}, 32'h0);
        pulse();
        tick(1);
        check({30'h0, halt, iack}, 32'h0);
        pulse();
        wait_ack();
        wait_load(6'h07, 8'hff, fl | 8'h80, sp - 24'h4);
        $display("test reset done");
    endtask
    task automatic test_trap(input logic s, input logic [1:0] t);
        int w0 = u_mem.writes;
        pc = 16'h1234 + {14'h0, t};
        fl = 8'h05;
        sp = 24'h00fe00;
        sel = s;
        tnum = t;
        lat = 2'h2;
        trap = 1'b1;
        tick(1);
        trap = 1'b0;
        wait_load(6'h08 + {4'h0, t}, 8'hff, {1'b1, ~s, 6'h05}, sp - 24'h4);
        check_push(w0);
        $display("test trap done");
    endtask
    task automatic test_prio;
        int w0;
        lat = 2'h1;
        irq = 1'b1;
        ivec = 6'h12;
        pulse();
        check({30'h0, halt, iack}, 32'h0);
        tick(1);
        ivec = 6'h3d;
        pulse();
        check({30'h0, halt, iack}, 32'h0);
        ivec = 6'h0d;
        tick(5);
        check({30'h0, halt, iack}, 32'h0);
        w0 = u_mem.writes;
        trap = 1'b1;
        done = 1'b1;
        tick(1);
        trap = 1'b0;
        done = 1'b0;
        wait_ack();
        wait_load(6'h0d, 8'h80, 8'h80, sp - 24'h4);
        check_push(w0);
        $display("test priority done");
    endtask
    initial begin
        tick(20);
        rst_n_in = 1'b1;
        tick(3);
        test_reset(1'b0);
        test_trap(1'b0, 2'h3);
        test_trap(1'b1, 2'h0);
        test_prio();
        test_reset(1'b1);
        test_reset(1'b0);
        conclude();
    end
    initial begin
        #(5000 * 100);
        errors++;
        conclude();
    end
endmodule
